// File: ebt_chk_placeholder_none.sv
// intentionally empty design note file: no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: ebt_count_src.sv
// count-enable source: event pin edge detect and prescaler taps
`timescale 1ns/1ps
`default_nettype none

module ebt_count_src #(
	parameter logic [29:0] EXP_TAB = ebt_pkg::EXP_UNIT0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic event_pin,
	input wire logic [2:0] sel,
	input wire logic run,
	output logic count_en
);

	// ---------------------------------------------------------------
	// elaboration check: every tap must fit the prescaler
	// ---------------------------------------------------------------
	for (genvar i = 0; i < 6; i++)
	begin : g_chk
		if (int'(EXP_TAB[5*i +: 5]) > ebt_pkg::DIV_W)
		begin : g_bad
			$error("prescaler tap exceeds divider width");
		end
	end

	// one cycle tick every 2^e cycles; e = 0 ticks always
	function automatic logic tap_tick(input logic [ebt_pkg::DIV_W-1:0] div,
		input logic [4:0] e);
		logic [ebt_pkg::DIV_W-1:0] mask;
		mask = ebt_pkg::DIV_W'((1 << e) - 1);
		tap_tick = &(div | ~mask);
	endfunction : tap_tick

	ebt_pkg::ebt_src_s q; // all state
	ebt_pkg::ebt_src_s d; // next state

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		logic en;
		logic [2:0] k;
		en = 1'b0;
		k = sel - ebt_pkg::SRC_FX;
		d = q;
		// sync1 feeds only sync2
		d.sync1 = event_pin;
		d.sync2 = q.sync1;
		d.prev = q.sync2;
		// prescaler free-runs so taps stay phase-aligned
		d.div = q.div + 1'b1;
		if (sel == ebt_pkg::SRC_FALL)
		begin
			en = q.prev & ~q.sync2; // falling edge
		end
		else if (sel == ebt_pkg::SRC_RISE)
		begin
			en = q.sync2 & ~q.prev; // rising edge
		end
		else
		begin
			en = tap_tick(q.div, EXP_TAB[5*k +: 5]);
		end
		// stopped timer ignores its inputs
		d.en = run & en;
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else
			q <= d;
	end

	assign count_en = q.en;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_fx_direct: assert property (@(posedge pclk) disable iff (!presetn)
		(run && sel == ebt_pkg::SRC_FX) |=> count_en)
		else $error("fx source did not tick every cycle");
	chk_div_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		(count_en && sel > ebt_pkg::SRC_FX && $stable(sel)) |=> !count_en)
		else $error("divided source ticked twice in a row");
	chk_edge_enable: assert property (@(posedge pclk) disable iff (!presetn)
		(run && sel == ebt_pkg::SRC_RISE && q.sync2 && !q.prev) |=> count_en)
		else $error("rising edge did not give a count enable");

endmodule : ebt_count_src

`default_nettype wire

// File: ebt_pkg.sv
// package: constants, types and register map of the 8-bit timer pair
// Function
// - unit 0 sources: edges, fx, /2, /4, /64, /256, /8192
// - unit 1 sources: edges, fx, /2, /16, /64, /256, /4096
// - source select resets to falling edge
// - run bit: 0 clears and stops, 1 counts
// - mode bit: clear-on-match or free-running PWM
// - set/reset pair: none, force 0, force 1
// - bit 1: toggle enable, or PWM active level
// - output enable 0 holds output low
// - set/reset bits always read as zero
// - set/reset ignored in PWM mode
// - PWM stopped drives output inactive
// - mode settings reach output even when stopped
// - mode register resets zero, byte writes accepted
// - counter increments on each selected count tick
// - match in clear mode raises interrupt and clears
// - PWM active on overflow, inactive on match
// - enabled inversion toggles flop on each match
`default_nettype none

package ebt_pkg;

	// ---------------------------------------------------------------
	// sizes
	// ---------------------------------------------------------------
	localparam int NUM_UNITS = 2; // two timer units, alike except for their tap tables
	localparam int ADDR_W = 18; // apb byte address width
	localparam int DIV_W = 13; // prescaler width, largest divide 2^13
	localparam int CSEL_W = 3; // source select field width

	// ---------------------------------------------------------------
	// register indices; byte address is four times the index
	// ---------------------------------------------------------------
	localparam logic [15:0] IDX_MODE0 = 16'hFF6B;
	localparam logic [15:0] IDX_MODE1 = 16'hFF43;
	localparam logic [15:0] IDX_CSEL0 = 16'hFF8A;
	localparam logic [15:0] IDX_CSEL1 = 16'hFF8C;
	localparam logic [15:0] IDX_CNT0 = 16'hFF16;
	localparam logic [15:0] IDX_CNT1 = 16'hFF1F;
	localparam logic [15:0] IDX_CMP0 = 16'hFF17;
	localparam logic [15:0] IDX_CMP1 = 16'hFF41;

	// ---------------------------------------------------------------
	// mode register bit positions
	// ---------------------------------------------------------------
	localparam int BIT_RUN = 7; // count_run_bit
	localparam int BIT_PWM = 6; // pwm_mode_bit
	localparam int BIT_SET = 3; // flop_set_cmd
	localparam int BIT_RST = 2; // flop_reset_cmd
	localparam int BIT_INV = 1; // invert_or_polarity_bit
	localparam int BIT_OE = 0; // output_enable_bit

	// ---------------------------------------------------------------
	// reset values and codes
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [2:0] RST_CSEL = 3'h0;
	localparam logic [7:0] RST_CMP = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hFF; // overflow point
	localparam logic [2:0] SRC_FALL = 3'h0;
	localparam logic [2:0] SRC_RISE = 3'h1;
	localparam logic [2:0] SRC_FX = 3'h2; // first prescaled code
	// divide exponents for codes 2..7, code 2 in the low field
	localparam logic [29:0] EXP_UNIT0 = {5'h0D, 5'h08, 5'h06, 5'h02, 5'h01, 5'h00};
	localparam logic [29:0] EXP_UNIT1 = {5'h0C, 5'h08, 5'h06, 5'h04, 5'h01, 5'h00};

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {K_MODE, K_CSEL, K_CMP, K_CNT} ebt_kind_e;

	typedef struct packed {
		logic hit; // address maps to a register
		ebt_kind_e kind; // which register of the unit
		logic unit; // unit number
	} ebt_sel_s;

	typedef struct packed {
		logic run; // count_run_bit
		logic pwm; // pwm_mode_bit
		logic pol; // invert_or_polarity_bit
		logic oe; // output_enable_bit
		logic ff; // timer output flop
		logic pwm_act; // pwm output flop, 1 = active
		logic irq; // match_irq pulse
		logic pin; // timer_output_pin
		logic [CSEL_W-1:0] csel; // count_source_select_reg
		logic [7:0] cmp; // compare_value
		logic [7:0] count; // count_value
	} ebt_unit_s;

	typedef struct packed {
		ebt_unit_s [NUM_UNITS-1:0] u;
		logic [7:0] prdata;
		logic pready;
		logic pslverr;
	} ebt_top_s;

	typedef struct packed {
		logic sync1; // first synchroniser stage
		logic sync2; // second synchroniser stage
		logic prev; // delayed copy for edge detect
		logic [DIV_W-1:0] div; // free-running prescaler
		logic en; // count enable
	} ebt_src_s;

endpackage : ebt_pkg

`default_nettype wire

// File: ebt_pulse_src.sv
// event pulse source model driving both timer event inputs
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// pulse source
// ------------------------------
module ebt_pulse_src (
	input wire logic pclk,
	output var logic [1:0] pin
);
	// idle low between bursts, no pull on the pin
	initial pin = 2'h0;
	// n pulses on one unit; len sets fast or slow edges
	task automatic burst(input int u, input int n, input int len);
		repeat (n)
		begin
			pin[u] <= 1'b1;
			repeat (len) @(posedge pclk);
			pin[u] <= 1'b0;
			repeat (len) @(posedge pclk);
		end
	endtask : burst
endmodule : ebt_pulse_src
`default_nettype wire

// File: ebt_top.sv
// two 8-bit timer/event counters with apb register access
`timescale 1ns/1ps
`default_nettype none

module ebt_top #(
	parameter int ADDR_W = ebt_pkg::ADDR_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] event_input_pin,
	output logic [1:0] timer_output_pin,
	output logic [1:0] match_irq
);

	// ---------------------------------------------------------------
	// elaboration check
	// ---------------------------------------------------------------
	if (ADDR_W < ebt_pkg::ADDR_W)
	begin : g_bad_addr
		$error("address bus too narrow for the register map");
	end

	// ---------------------------------------------------------------
	// address decode, shared by read and write paths
	// ---------------------------------------------------------------
	function automatic ebt_pkg::ebt_sel_s reg_decode(input logic [ADDR_W-3:0] idx);
		ebt_pkg::ebt_sel_s s;
		s = '{hit: 1'b1, kind: ebt_pkg::K_MODE, unit: 1'b0};
		if (idx == (ADDR_W-2)'(ebt_pkg::IDX_MODE0))
			s = '{hit: 1'b1, kind: ebt_pkg::K_MODE, unit: 1'b0};
		else if (idx == (ADDR_W-2)'(ebt_pkg::IDX_MODE1))
			s = '{hit: 1'b1, kind: ebt_pkg::K_MODE, unit: 1'b1};
		else if (idx == (ADDR_W-2)'(ebt_pkg::IDX_CSEL0))
			s = '{hit: 1'b1, kind: ebt_pkg::K_CSEL, unit: 1'b0};
		else if (idx == (ADDR_W-2)'(ebt_pkg::IDX_CSEL1))
			s = '{hit: 1'b1, kind: ebt_pkg::K_CSEL, unit: 1'b1};
		else if (idx == (ADDR_W-2)'(ebt_pkg::IDX_CMP0))
			s = '{hit: 1'b1, kind: ebt_pkg::K_CMP, unit: 1'b0};
		else if (idx == (ADDR_W-2)'(ebt_pkg::IDX_CMP1))
			s = '{hit: 1'b1, kind: ebt_pkg::K_CMP, unit: 1'b1};
		else if (idx == (ADDR_W-2)'(ebt_pkg::IDX_CNT0))
			s = '{hit: 1'b1, kind: ebt_pkg::K_CNT, unit: 1'b0};
		else if (idx == (ADDR_W-2)'(ebt_pkg::IDX_CNT1))
			s = '{hit: 1'b1, kind: ebt_pkg::K_CNT, unit: 1'b1};
		else
			s.hit = 1'b0; // unmapped: answered with pslverr
		return s;
	endfunction : reg_decode

	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	ebt_pkg::ebt_top_s q; // all state
	ebt_pkg::ebt_top_s d; // next state
	ebt_pkg::ebt_sel_s rs; // decoded address
	logic wr; // write takes effect this edge
	logic setup; // apb setup cycle
	logic [1:0] count_en; // per-unit count tick
	logic [1:0] wr_mode; // mode register write per unit

	assign rs = reg_decode(paddr[ADDR_W-1:2]);
	assign setup = psel & ~penable;
	// only the low byte lane carries register data
	assign wr = psel & penable & q.pready & pwrite & pstrb[0] & rs.hit;

	// ---------------------------------------------------------------
	// count sources, one per unit with its own tap table
	// ---------------------------------------------------------------
	for (genvar g = 0; g < ebt_pkg::NUM_UNITS; g++)
	begin : g_src
		localparam logic [29:0] TAB = (g == 0) ? ebt_pkg::EXP_UNIT0 : ebt_pkg::EXP_UNIT1;
		ebt_count_src #(
			.EXP_TAB(TAB)
		) u_src (
			.pclk(pclk),
			.presetn(presetn),
			.event_pin(event_input_pin[g]),
			.sel(q.u[g].csel),
			.run(q.u[g].run),
			.count_en(count_en[g])
		);
		assign wr_mode[g] = wr & (rs.kind == ebt_pkg::K_MODE) & (rs.unit == 1'(g));
	end

	// ---------------------------------------------------------------
	// next state: bus slave, register writes, counters, outputs
	// ---------------------------------------------------------------
	always_comb
	begin
		ebt_pkg::ebt_unit_s r;
		logic wu;
		logic match;
		r = q.u[rs.unit];
		wu = 1'b0;
		match = 1'b0;
		d = q;
		// one wait-free access phase: ready rises after setup
		d.pready = setup;
		// error flag stands only beside ready, never lingers
		d.pslverr = 1'b0;
		if (setup)
		begin
			d.pslverr = ~rs.hit;
			unique case (rs.kind)
				// set/reset commands read as zero
				ebt_pkg::K_MODE: d.prdata = {r.run, r.pwm, 4'h0, r.pol, r.oe};
				ebt_pkg::K_CSEL: d.prdata = {5'h00, r.csel};
				ebt_pkg::K_CMP: d.prdata = r.cmp;
				ebt_pkg::K_CNT: d.prdata = r.count;
			endcase
			if (!rs.hit)
				d.prdata = 8'h00; // unmapped reads zero
		end
		for (int i = 0; i < ebt_pkg::NUM_UNITS; i++)
		begin
			wu = wr & (rs.unit == 1'(i));
			d.u[i].irq = 1'b0;
			// register writes; a byte write is the only form
			if (wu)
			begin
				unique case (rs.kind)
					ebt_pkg::K_MODE:
					begin
						d.u[i].run = pwdata[ebt_pkg::BIT_RUN];
						d.u[i].pwm = pwdata[ebt_pkg::BIT_PWM];
						d.u[i].pol = pwdata[ebt_pkg::BIT_INV];
						d.u[i].oe = pwdata[ebt_pkg::BIT_OE];
						// preset only outside PWM; code 11 is ignored
						if (!pwdata[ebt_pkg::BIT_PWM])
						begin
							if (pwdata[ebt_pkg::BIT_SET] && !pwdata[ebt_pkg::BIT_RST])
								d.u[i].ff = 1'b1;
							else if (!pwdata[ebt_pkg::BIT_SET] && pwdata[ebt_pkg::BIT_RST])
								d.u[i].ff = 1'b0;
						end
					end
					// upper five bits are not stored
					ebt_pkg::K_CSEL: d.u[i].csel = pwdata[ebt_pkg::CSEL_W-1:0];
					ebt_pkg::K_CMP: d.u[i].cmp = pwdata[7:0];
					ebt_pkg::K_CNT: ; // counter is read-only
				endcase
			end
			match = (q.u[i].count == q.u[i].cmp);
			// stopped: counter held at zero, pwm made inactive
			if (!d.u[i].run)
			begin
				d.u[i].count = 8'h00;
				d.u[i].pwm_act = 1'b0;
			end
			else if (count_en[i])
			begin
				if (!q.u[i].pwm)
				begin
					if (match)
					begin
						// clear and start, interrupt on match
						d.u[i].count = 8'h00;
						d.u[i].irq = 1'b1;
						if (q.u[i].pol)
							d.u[i].ff = ~d.u[i].ff; // square wave
					end
					else
					begin
						d.u[i].count = q.u[i].count + 8'h01;
					end
				end
				else
				begin
					// free-running: wraps, no clear on match
					d.u[i].count = q.u[i].count + 8'h01;
					// overflow wins over a match on the same tick
					if (q.u[i].count == ebt_pkg::COUNT_MAX)
						d.u[i].pwm_act = 1'b1;
					else if (match)
						d.u[i].pwm_act = 1'b0;
				end
			end
			// output follows settings even when stopped
			if (!d.u[i].oe)
				d.u[i].pin = 1'b0;
			else if (d.u[i].pwm)
				d.u[i].pin = d.u[i].pwm_act ^ d.u[i].pol;
			else
				d.u[i].pin = d.u[i].ff;
		end
	end

	// ---------------------------------------------------------------
	// state register, all fields clear to zero
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else
			q <= d;
	end

	// ---------------------------------------------------------------
	// outputs, each straight from the state register
	// ---------------------------------------------------------------
	assign prdata = {24'h000000, q.prdata};
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	for (genvar g = 0; g < ebt_pkg::NUM_UNITS; g++)
	begin : g_out
		assign timer_output_pin[g] = q.u[g].pin;
		assign match_irq[g] = q.u[g].irq;
	end

	// ---------------------------------------------------------------
	// checks per unit
	// ---------------------------------------------------------------
	for (genvar g = 0; g < ebt_pkg::NUM_UNITS; g++)
	begin : g_chk
		chk_reset_select: assert property (@(posedge pclk)
			$rose(presetn) |-> (q.u[g].csel == ebt_pkg::RST_CSEL))
			else $error("source select not zero after reset");
		chk_reset_mode: assert property (@(posedge pclk)
			$rose(presetn) |-> (!q.u[g].run && !q.u[g].pwm && !q.u[g].oe && !q.u[g].pol))
			else $error("mode register not zero after reset");
		chk_byte_write: assert property (@(posedge pclk) disable iff (!presetn)
			wr_mode[g] |=> (q.u[g].run == $past(pwdata[7]) && q.u[g].pwm == $past(pwdata[6])))
			else $error("mode write not stored");
		chk_stop_clears: assert property (@(posedge pclk) disable iff (!presetn)
			!q.u[g].run |-> (q.u[g].count == 8'h00))
			else $error("counter not cleared while stopped");
		chk_count_step: assert property (@(posedge pclk) disable iff (!presetn)
			(q.u[g].run && count_en[g] && !wr_mode[g] && q.u[g].count != q.u[g].cmp)
			|=> (q.u[g].count == $past(q.u[g].count) + 8'h01))
			else $error("counter did not step on count tick");
		chk_match_clear: assert property (@(posedge pclk) disable iff (!presetn)
			(q.u[g].run && count_en[g] && !q.u[g].pwm && !wr_mode[g]
			&& q.u[g].count == q.u[g].cmp) |=> (q.u[g].count == 8'h00 && match_irq[g]))
			else $error("match did not clear and interrupt");
		chk_pwm_no_clear: assert property (@(posedge pclk) disable iff (!presetn)
			(q.u[g].run && count_en[g] && q.u[g].pwm && !wr_mode[g]
			&& q.u[g].count == q.u[g].cmp) |=> (!match_irq[g] && q.u[g].count != 8'h00
			|| $past(q.u[g].count) == ebt_pkg::COUNT_MAX))
			else $error("pwm mode cleared counter on match");
		chk_pwm_overflow: assert property (@(posedge pclk) disable iff (!presetn)
			(q.u[g].run && count_en[g] && q.u[g].pwm && !wr_mode[g]
			&& q.u[g].count == ebt_pkg::COUNT_MAX) |=> q.u[g].pwm_act)
			else $error("overflow did not activate pwm");
		chk_toggle: assert property (@(posedge pclk) disable iff (!presetn)
			(q.u[g].run && count_en[g] && !q.u[g].pwm && q.u[g].pol && !wr_mode[g]
			&& q.u[g].count == q.u[g].cmp) |=> (q.u[g].ff != $past(q.u[g].ff)))
			else $error("match did not toggle output flop");
		chk_preset_set: assert property (@(posedge pclk) disable iff (!presetn)
			(wr_mode[g] && pwdata[7:6] == 2'b00 && pwdata[3:2] == 2'b10) |=> q.u[g].ff)
			else $error("set command ignored");
		chk_preset_clr: assert property (@(posedge pclk) disable iff (!presetn)
			(wr_mode[g] && pwdata[7:6] == 2'b00 && pwdata[3:2] == 2'b01) |=> !q.u[g].ff)
			else $error("reset command ignored");
		chk_pwm_preset: assert property (@(posedge pclk) disable iff (!presetn)
			(wr_mode[g] && pwdata[6]) |=> $stable(q.u[g].ff))
			else $error("preset acted in pwm mode");
		chk_out_disable: assert property (@(posedge pclk) disable iff (!presetn)
			(!q.u[g].oe && !wr_mode[g]) |=> !timer_output_pin[g])
			else $error("disabled output not low");
		chk_pwm_level: assert property (@(posedge pclk) disable iff (!presetn)
			(q.u[g].pwm && q.u[g].oe && !wr_mode[g] && !count_en[g] && q.u[g].run)
			|=> (timer_output_pin[g] == ($past(q.u[g].pwm_act) ^ $past(q.u[g].pol))))
			else $error("pwm output level wrong");
		chk_pwm_stop: assert property (@(posedge pclk) disable iff (!presetn)
			(q.u[g].pwm && !q.u[g].run && q.u[g].oe && !wr_mode[g])
			|=> (timer_output_pin[g] == $past(q.u[g].pol)))
			else $error("stopped pwm output not inactive");
		chk_immediate: assert property (@(posedge pclk) disable iff (!presetn)
			(wr_mode[g] && pwdata[7:6] == 2'b00 && pwdata[3:2] == 2'b10 && pwdata[0])
			|=> timer_output_pin[g])
			else $error("stopped output did not follow preset");
		chk_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
			(setup && rs.hit && rs.kind == ebt_pkg::K_MODE) |=> (prdata[3:2] == 2'b00))
			else $error("set/reset bits read nonzero");
		cov_interval: cover property (@(posedge pclk) disable iff (!presetn)
			match_irq[g] ##1 !match_irq[g] [*2] ##1 match_irq[g]);
		cov_pwm_cycle: cover property (@(posedge pclk) disable iff (!presetn)
			q.u[g].pwm && $rose(q.u[g].pwm_act) ##[1:600] $fell(q.u[g].pwm_act));
		cov_square: cover property (@(posedge pclk) disable iff (!presetn)
			!q.u[g].pwm && $rose(timer_output_pin[g]) ##[1:600] $fell(timer_output_pin[g]));
	end

endmodule : ebt_top

`default_nettype wire

// File: tb.sv
// self-checking testbench for the two 8-bit timer units
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// bench top
// ------------------------------
module tb;
	logic pclk, presetn, psel, penable, pwrite, e;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic pready, pslverr;
	logic [1:0] evt, tout, irq;
	int bad_count = 0, cmp_count = 0, cyc = 0, t_rd = 0;
	// register indices per unit: mode, source, count
	logic [15:0] mi[2] = '{ebt_pkg::IDX_MODE0, ebt_pkg::IDX_MODE1};
	logic [15:0] ci[2] = '{ebt_pkg::IDX_CSEL0, ebt_pkg::IDX_CSEL1};
	logic [15:0] ni[2] = '{ebt_pkg::IDX_CNT0, ebt_pkg::IDX_CNT1};
	// divide exponents for codes 2..7
	int kt[2][6] = '{'{0, 1, 2, 6, 8, 13}, '{0, 1, 4, 6, 8, 12}};
	ebt_top #(.ADDR_W(18)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.event_input_pin(evt), .timer_output_pin(tout), .match_irq(irq));
	ebt_pulse_src src (.pclk(pclk), .pin(evt));
	// 25 ns clock
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	// ------------------------------
	// shared tasks
	// ------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer; holds the request until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		// answer taken at the very edge where pready is sampled high
		r = prdata;
		e = pslverr;
		t_rd = cyc;
		if (n >= 20) bad_count++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(r, exp);
	endtask : rdc
	// output level is settled one cycle after the write edge
	task automatic pinchk(input int u, input logic exp);
		@(negedge pclk);
		chk({31'h0, tout[u]}, {31'h0, exp});
		@(posedge pclk);
	endtask : pinchk
	// ------------------------------
	// scenarios
	// ------------------------------
	task automatic t_reset();
		rdc(mi[0], 32'h0);
		rdc(ci[0], 32'h0);
		rdc(mi[1], 32'h0);
		rdc(ci[1], 32'h0);
		apb(1'b0, 16'h0000, 8'h00);
		chk({31'h0, e}, 32'h1);
	endtask : t_reset
	task automatic t_pwm();
		int hi;
		hi = 0;
		apb(1'b1, ci[0], 8'h02);
		apb(1'b1, ebt_pkg::IDX_CMP0, 8'h04);
		apb(1'b1, mi[0], 8'h40);
		apb(1'b1, mi[0], 8'h41);
		apb(1'b1, mi[0], 8'hC1);
		repeat (200) @(posedge pclk);
		repeat (512)
		begin
			@(negedge pclk);
			hi += tout[0];
		end
		@(posedge pclk);
		chk(hi, 32'hA);
		apb(1'b1, mi[0], 8'h41);
		pinchk(0, 1'b0);
		apb(1'b1, mi[0], 8'h43);
		pinchk(0, 1'b1);
		apb(1'b1, mi[0], 8'h4B);
		rdc(mi[0], 32'h43);
		apb(1'b1, mi[0], 8'h03);
		pinchk(0, 1'b0);
	endtask : t_pwm
	task automatic t_sq();
		int tg, iq;
		logic p;
		tg = 0;
		iq = 0;
		apb(1'b1, ci[1], 8'h02);
		apb(1'b1, ebt_pkg::IDX_CMP1, 8'h03);
		apb(1'b1, mi[1], 8'h02);
		apb(1'b1, mi[1], 8'h03);
		apb(1'b1, mi[1], 8'h0B);
		pinchk(1, 1'b1);
		rdc(mi[1], 32'h03);
		apb(1'b1, mi[1], 8'h8B);
		@(negedge pclk);
		p = tout[1];
		repeat (64)
		begin
			@(negedge pclk);
			tg += (tout[1] !== p);
			iq += irq[1];
			p = tout[1];
		end
		@(posedge pclk);
		chk(tg, 32'h10);
		chk(iq, 32'h10);
		apb(1'b1, mi[1], 8'h03);
		rdc(ni[1], 32'h0);
		apb(1'b1, mi[1], 8'h07);
		pinchk(1, 1'b0);
		apb(1'b1, mi[1], 8'h0B);
		apb(1'b1, mi[1], 8'h0A);
		pinchk(1, 1'b0);
	endtask : t_sq
	task automatic t_evt();
		for (int u = 0; u < 2; u++)
		begin
			apb(1'b1, mi[u], 8'h00);
			apb(1'b1, ci[u], u[7:0]);
			apb(1'b1, u ? ebt_pkg::IDX_CMP1 : ebt_pkg::IDX_CMP0, 8'hFF);
			apb(1'b1, mi[u], 8'h80);
			src.burst(u, 3, u ? 4 : 1);
			repeat (4) @(posedge pclk);
			rdc(ni[u], 32'h3);
		end
	endtask : t_evt
	task automatic t_div();
		logic [31:0] a;
		int t0;
		int n;
		for (int u = 0; u < 2; u++)
			for (int c = 2; c < 8; c++)
			begin
				// window is a whole number of tick periods, at least one tick
				n = (kt[u][c-2] > 7) ? (1 << kt[u][c-2]) : 128;
				apb(1'b1, mi[u], 8'h00);
				apb(1'b1, ci[u], c[7:0]);
				apb(1'b1, mi[u], 8'h80);
				apb(1'b0, ni[u], 8'h00);
				a = r;
				t0 = t_rd;
				// second read samples the count n cycles after the first
				while (cyc < t0 + n - 2) @(posedge pclk);
				apb(1'b0, ni[u], 8'h00);
				chk(r - a, (t_rd - t0) >> kt[u][c-2]);
			end
	endtask : t_div
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	// main sequence
	initial
	begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 18'h00000;
		pwdata = 32'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_pwm();
		t_sq();
		t_evt();
		t_div();
		print_verdict();
	end
	// watchdog well beyond the roughly 15000 cycles needed
	initial
	begin
		repeat (40000) @(posedge pclk);
		bad_count++;
		print_verdict();
	end
endmodule : tb
`default_nettype wire
